// file: wrx_pkg.sv
// Constants, types and register map of the wireless receiver control block.
// Assumes rail, input and load figures arrive as mV/mA codes on clk_sys.
`default_nettype none
package wrx_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int BIT_CLK_HZ = 2_000;
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_CLK_HZ);
  // ----------------------------------------
  // Levels (mV, mA, ohm)
  // ----------------------------------------
  localparam logic [15:0] VIN_MAX_MV = 16'h3A98;
  localparam logic [15:0] RAIL_SAFE_MV = 16'h1B58;
  localparam logic [15:0] SYNC_WPC_MV = 16'h1B58;
  localparam logic [15:0] SYNC_PMA_MV = 16'h15E0;
  localparam logic [15:0] TGT_R1_MV = 16'h1B58;
  localparam logic [15:0] TGT_R2_MV = 16'h189C;
  localparam logic [15:0] TGT_R3_MV = 16'h157C;
  localparam logic [15:0] TGT_R4_MV = 16'h154A;
  localparam logic [15:0] OVP_MV = 16'h4268;
  localparam logic [15:0] OVP_HYST_MV = 16'h01F4;
  localparam logic [15:0] UVLO_MV = 16'h0FA0;
  localparam logic [15:0] FULL_SYNC_MA = 16'h012C;
  localparam logic [15:0] CURRENT_LIMIT_LEVEL_CLAMP_MA = 16'h07D0;
  localparam logic [16:0] LIMIT_RESISTOR_MIN_OHM = 17'h0_61A8;
  localparam logic [31:0] LIM_NUM = 32'h02AE_A540;
  localparam logic [31:0] SET_NUM = 32'h0243_D580;
  // ----------------------------------------
  // Packet codes
  // ----------------------------------------
  localparam logic [7:0] HDR_SS = 8'h01;
  localparam logic [7:0] HDR_EOP = 8'h02;
  localparam logic [7:0] HDR_CE = 8'h03;
  localparam logic [7:0] HDR_CS = 8'h05;
  localparam logic [7:0] HDR_CFG = 8'h51;
  localparam logic [7:0] HDR_ID = 8'h71;
  localparam logic [7:0] HDR_EOC = 8'hE0;
  localparam logic [7:0] EOP_CHG = 8'h01;
  localparam logic [7:0] EOP_OT = 8'h03;
  localparam logic [7:0] EOP_OC = 8'h04;
  localparam logic [7:0] CS_FULL = 8'h64;
  localparam logic [3:0] FRAME_LAST = 4'hA;
  localparam logic [1:0] BYTE_LAST = 2'h2;
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FOD = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_FAULT = 8'h0C;
  localparam logic [7:0] REG_LIMIT = 8'h10;
  localparam logic [7:0] REG_FODEFF = 8'h14;
  localparam int CTRL_CS = 0;
  localparam int CTRL_PMA = 1;
  // FOD tables: values arbitrary, one-time programmed in the real part
  localparam logic [3:0] FOD_SLOTS = 4'hA;
  localparam logic [15:0] FOD_OTP [10] = '{16'h0100, 16'h0120, 16'h0140, 16'h0160,
    16'h0180, 16'h01A0, 16'h01C0, 16'h01E0, 16'h0200, 16'h0220};
  localparam logic [3:0] FOD_OFS_MAX = 4'hC;
  localparam logic [15:0] FOD_STEP_MW = 16'h0032;
  localparam logic [15:0] FOD_OFS_NEG_MW = 16'h012C;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {PH_SEL, PH_PING, PH_IDCFG, PH_XFER} wrx_phase_t;
  typedef enum logic [1:0] {RECT_DIODE, RECT_HALF, RECT_FULL} wrx_rect_t;
  typedef struct packed {
    logic [15:0] vin_mv;
    logic [15:0] rectified_rail_mv;
    logic [15:0] iout_ma;
  } wrx_meas_t;
  typedef struct packed {
    logic [7:0] hdr;
    logic [7:0] body;
  } wrx_pkt_t;
endpackage : wrx_pkg
`default_nettype wire

// file: wrx_ctrl.sv
// Receiver control: protection, rail target, phase sequencing, bi-phase
// modulator and a small register port. Measurements are on clk_sys.
`default_nettype none
module wrx_ctrl
  import wrx_pkg::*;
#(
  parameter int HALF_BIT = HALF_BIT_CYC,
  parameter logic [7:0] ID_BODY = 8'h5A,
  parameter logic [7:0] CFG_BODY = 8'h0A
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Measurements and straps
  input wire wrx_meas_t meas,
  input wire logic die_hot,
  input wire logic [16:0] limit_resistor,
  input wire logic [3:0] fod_profile_select,
  input wire logic [3:0] fod_offset_select,
  // Pins
  input wire logic sleep_req_n,
  input wire logic thermal_stop_input,
  input wire logic charge_done_input,
  // Power and status outputs
  output logic ldo_en,
  output logic rail_clamp_a,
  output logic rail_clamp_b,
  output logic pin_clamp,
  output wrx_rect_t rect_mode,
  output logic [15:0] rail_target_mv,
  output logic power_ok_n,
  output logic fault_n,
  output logic sleep_mode,
  output logic [15:0] fod_level_mw,
  // Modulation switches
  output logic coil_input_a_sw,
  output logic coil_input_b_sw
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  wire [2:0] pin_raw = {charge_done_input, thermal_stop_input, sleep_req_n};
  wire [2:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);
  wire [2:0] pin_f_d = (pin_agree & pin_s2_q) | (~pin_agree & pin_f_q);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
      pin_f_q <= 3'h0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
    end
  end
  wire sleep_w = pin_f_q[0];
  wire therm_w = pin_f_q[1];
  wire chg_w = pin_f_q[2];

  // ----------------------------------------
  // Limits and rail target
  // ----------------------------------------
  wire [16:0] limit_resistor_nz = (limit_resistor == 17'h0_0000) ? 17'h0_0001 : limit_resistor;
  wire [31:0] current_limit_level_calc = LIM_NUM / {15'h0000, limit_resistor_nz};
  wire [31:0] region_reference_current = SET_NUM / {15'h0000, limit_resistor_nz};
  wire limit_resistor_low = limit_resistor < LIMIT_RESISTOR_MIN_OHM;
  wire [15:0] current_limit_level_ma = limit_resistor_low ? CURRENT_LIMIT_LEVEL_CLAMP_MA : current_limit_level_calc[15:0];
  wire [31:0] iout_w = {16'h0000, meas.iout_ma};
  wire [31:0] th10 = region_reference_current / 32'h0000_000A;
  wire [31:0] th20 = region_reference_current / 32'h0000_0005;
  wire [31:0] th40 = 32'((region_reference_current * 32'h0000_0002) / 32'h0000_0005);
  wire [15:0] rail = meas.rectified_rail_mv;
  wire ov_in = meas.vin_mv > VIN_MAX_MV;
  wire [15:0] target_d = ov_in ? RAIL_SAFE_MV :
                         (iout_w < th10) ? TGT_R1_MV :
                         (iout_w < th20) ? TGT_R2_MV :
                         (iout_w < th40) ? TGT_R3_MV : TGT_R4_MV;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic [1:0] ctrl_q;
  logic [15:0] fod_vol_q;
  logic [2:0] flag_q;
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire wr_fod = reg_wr && (reg_addr == REG_FOD);
  wire wr_fault = reg_wr && (reg_addr == REG_FAULT);
  wire cs_mode = ctrl_q[CTRL_CS];
  wire pma_mode = ctrl_q[CTRL_PMA];

  // ----------------------------------------
  // Protection
  // ----------------------------------------
  logic clamp_q, stop_q, sync_arm_q, ldo_q, fault_n_q;
  logic [7:0] stop_rsn_q;
  wrx_phase_t phase_q;
  wire oc = meas.iout_ma >= current_limit_level_ma;
  wire ot = die_hot;
  wire ovp_hi = rail > OVP_MV;
  wire ovp_lo = rail < (OVP_MV - OVP_HYST_MV);
  wire clamp_d = ovp_hi | (clamp_q & ~ovp_lo);
  wire [2:0] flag_ev = {ot | therm_w, ov_in | ovp_hi, oc};
  // A new event wins over a clear in the same cycle
  wire [2:0] flag_d = (flag_q & ~(wr_fault ? reg_wdata[2:0] : 3'h0)) | flag_ev;
  wire in_xfer = phase_q == PH_XFER;
  wire chg_stop = chg_w & ~cs_mode;
  wire stop_set = in_xfer & (oc | ot | therm_w | chg_stop);
  wire [7:0] rsn_d = (ot | therm_w) ? EOP_OT : oc ? EOP_OC : EOP_CHG;
  wire [15:0] sync_thr = pma_mode ? SYNC_PMA_MV : SYNC_WPC_MV;
  wire power_lost = rail < UVLO_MV;
  wire arm_d = ~sleep_w & ~power_lost & (sync_arm_q | (rail > sync_thr));
  wire ldo_d = in_xfer & sync_arm_q & ~ov_in & ~oc & ~ot & ~therm_w & ~stop_q
               & ~stop_set & ~sleep_w;
  wrx_rect_t rect_d;
  assign rect_d = ~arm_d ? RECT_DIODE :
                  (meas.iout_ma >= FULL_SYNC_MA) ? RECT_FULL : RECT_HALF;

  // ----------------------------------------
  // Packet choice
  // ----------------------------------------
  logic tx_busy_q, id_sent_q, tx_done;
  wrx_pkt_t pkt_q, nxt;
  wire eop_now = stop_q | stop_set | oc | ot | therm_w;
  wire [7:0] eop_rsn = stop_q ? stop_rsn_q : rsn_d;
  wire eoc_now = pma_mode & chg_w;
  wire signed [16:0] err = $signed({1'b0, rail_target_mv}) - $signed({1'b0, rail});
  wire signed [16:0] err_s = err >>> 5;
  wire [7:0] ce_val = (err_s > 17'sd127) ? 8'h7F :
                      (err_s < -17'sd128) ? 8'h80 : err_s[7:0];
  assign nxt.hdr = (phase_q == PH_PING) ? (eop_now ? HDR_EOP : HDR_SS) :
                   (phase_q == PH_IDCFG) ? (id_sent_q ? HDR_CFG : HDR_ID) :
                   eoc_now ? HDR_EOC :
                   eop_now ? HDR_EOP :
                   (cs_mode & chg_w) ? HDR_CS : HDR_CE;
  assign nxt.body = (nxt.hdr == HDR_EOP) ? eop_rsn :
                    (nxt.hdr == HDR_CS) ? CS_FULL :
                    (nxt.hdr == HDR_ID) ? ID_BODY :
                    (nxt.hdr == HDR_CFG) ? CFG_BODY :
                    (nxt.hdr == HDR_SS) ? rail[15:8] :
                    (nxt.hdr == HDR_EOC) ? 8'h00 : ce_val;
  wire can_tx = (phase_q != PH_SEL) & ~sleep_w & ~power_lost;
  wire tx_go = can_tx & ~tx_busy_q;

  // ----------------------------------------
  // Phase sequencer
  // ----------------------------------------
  wrx_phase_t phase_d;
  always_comb begin
    phase_d = phase_q;
    if (sleep_w || power_lost) begin
      phase_d = PH_SEL;
    end else begin
      case (phase_q)
        PH_SEL: phase_d = PH_PING;
        PH_PING: if (tx_done && pkt_q.hdr == HDR_SS) phase_d = PH_IDCFG;
        PH_IDCFG: if (tx_done && pkt_q.hdr == HDR_CFG) phase_d = PH_XFER;
        PH_XFER: phase_d = PH_XFER;
        default: phase_d = PH_SEL;
      endcase
    end
  end

  // ----------------------------------------
  // Bi-phase modulator
  // ----------------------------------------
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic half_q, mod_q;
  wire tick = tx_busy_q && (cnt_q == 16'(HALF_BIT - 1));
  wire [7:0] cur_byte = (byte_q == 2'h0) ? pkt_q.hdr :
                        (byte_q == 2'h1) ? pkt_q.body : pkt_q.hdr ^ pkt_q.body;
  wire parity = ~^cur_byte;
  wire [10:0] frame = {1'b1, parity, cur_byte, 1'b0};
  wire cur_bit = frame[bit_q];
  wire last_bit = (bit_q == FRAME_LAST) && (byte_q == BYTE_LAST);
  assign tx_done = tick && half_q && last_bit;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_busy_q <= 1'b0;
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      half_q <= 1'b0;
      mod_q <= 1'b0;
      pkt_q <= '0;
    end else if (!can_tx) begin
      tx_busy_q <= 1'b0;
      mod_q <= 1'b0;
    end else if (tx_go) begin
      tx_busy_q <= 1'b1;
      pkt_q <= nxt;
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      half_q <= 1'b0;
      mod_q <= ~mod_q;
    end else if (tick) begin
      cnt_q <= 16'h0000;
      half_q <= ~half_q;
      if (!half_q) begin
        mod_q <= mod_q ^ cur_bit;
      end else if (last_bit) begin
        tx_busy_q <= 1'b0;
        mod_q <= 1'b0;
      end else begin
        mod_q <= ~mod_q;
        bit_q <= (bit_q == FRAME_LAST) ? 4'h0 : bit_q + 4'h1;
        byte_q <= (bit_q == FRAME_LAST) ? byte_q + 2'h1 : byte_q;
      end
    end else if (tx_busy_q) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // FOD level
  // ----------------------------------------
  wire [15:0] fod_base = (fod_profile_select < FOD_SLOTS) ?
                         FOD_OTP[fod_profile_select] : fod_vol_q;
  wire [3:0] ofs_code = (fod_offset_select > FOD_OFS_MAX) ? FOD_OFS_MAX : fod_offset_select;
  wire [15:0] fod_d = 16'(fod_base + 16'({12'h000, ofs_code} * FOD_STEP_MW)
                      - FOD_OFS_NEG_MW);

  // ----------------------------------------
  // State and outputs
  // ----------------------------------------
  logic [15:0] target_q, fod_q;
  logic clamp_pin_q, stat_n_q, sleep_q;
  wrx_rect_t rect_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q <= 2'h0;
      fod_vol_q <= 16'h0000;
      flag_q <= 3'h0;
      fault_n_q <= 1'b1;
      clamp_q <= 1'b0;
      clamp_pin_q <= 1'b0;
      stop_q <= 1'b0;
      stop_rsn_q <= 8'h00;
      sync_arm_q <= 1'b0;
      ldo_q <= 1'b0;
      rect_q <= RECT_DIODE;
      target_q <= RAIL_SAFE_MV;
      phase_q <= PH_SEL;
      id_sent_q <= 1'b0;
      stat_n_q <= 1'b1;
      sleep_q <= 1'b0;
      fod_q <= 16'h0000;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata[1:0];
      if (wr_fod) fod_vol_q <= reg_wdata[15:0];
      flag_q <= flag_d;
      fault_n_q <= ~|flag_d;
      clamp_q <= clamp_d;
      clamp_pin_q <= ov_in;
      if (phase_d != PH_XFER) stop_q <= 1'b0;
      else if (stop_set && !stop_q) stop_q <= 1'b1;
      if (stop_set && !stop_q) stop_rsn_q <= rsn_d;
      sync_arm_q <= arm_d;
      ldo_q <= ldo_d;
      rect_q <= rect_d;
      target_q <= target_d;
      phase_q <= phase_d;
      if (phase_q != PH_IDCFG) id_sent_q <= 1'b0;
      else if (tx_done && pkt_q.hdr == HDR_ID) id_sent_q <= 1'b1;
      stat_n_q <= phase_d != PH_XFER;
      sleep_q <= sleep_w;
      fod_q <= fod_d;
    end
  end

  // Read data valid only in the cycle after the strobe
  logic [31:0] rdata_q;
  wire [31:0] stat_w = {21'h00_0000, flag_q, clamp_q, ldo_q, rect_q, phase_q, sleep_q, stop_q};
  wire [31:0] rd_mux = (reg_addr == REG_CTRL) ? {30'h0000_0000, ctrl_q} :
                       (reg_addr == REG_FOD) ? {16'h0000, fod_vol_q} :
                       (reg_addr == REG_STAT) ? stat_w :
                       (reg_addr == REG_FAULT) ? {29'h0000_0000, flag_q} :
                       (reg_addr == REG_LIMIT) ? {16'h0000, current_limit_level_ma} :
                       (reg_addr == REG_FODEFF) ? {16'h0000, fod_q} : 32'h0000_0000;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rdata_q <= 32'h0000_0000;
    else rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  assign reg_rdata = rdata_q;
  assign ldo_en = ldo_q;
  assign rail_clamp_a = clamp_q;
  assign rail_clamp_b = clamp_q;
  assign pin_clamp = clamp_pin_q;
  assign rect_mode = rect_q;
  assign rail_target_mv = target_q;
  assign power_ok_n = stat_n_q;
  assign fault_n = fault_n_q;
  assign sleep_mode = sleep_q;
  assign fod_level_mw = fod_q;
  assign coil_input_a_sw = mod_q;
  assign coil_input_b_sw = mod_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_OVIN_LDO: assert property (ov_in |=> !ldo_en && pin_clamp)
    else $error("LDO on or pins unclamped during input overvoltage");
  AST_CLAMP_HOLD: assert property (clamp_q && !ovp_lo |=> rail_clamp_a && rail_clamp_b)
    else $error("Rail clamp released above hysteresis level");
  AST_OC_EOP: assert property (in_xfer && oc && !sleep_w && !power_lost |=> !ldo_en)
    else $error("LDO left on during overcurrent");
  AST_CURRENT_LIMIT_LEVEL_CLAMP: assert property (limit_resistor_low |-> current_limit_level_ma == CURRENT_LIMIT_LEVEL_CLAMP_MA)
    else $error("Current limit not clamped for low resistor");
  AST_RECT_DIODE: assert property (!sync_arm_q && rail <= sync_thr |=> rect_mode == RECT_DIODE)
    else $error("Synchronous rectifier enabled below threshold");
  AST_STAT: assert property ((phase_q == PH_XFER) [*2] |-> !power_ok_n)
    else $error("Status output high during power transfer");
  AST_FAULT: assert property (|flag_ev |=> !fault_n)
    else $error("Fault output not low after event");
  AST_SLEEP: assert property (sleep_w |=> phase_q == PH_SEL ##1 !coil_input_a_sw)
    else $error("Activity while sleep requested");
  AST_FRAME: assert property (tx_busy_q |-> bit_q <= FRAME_LAST && byte_q <= BYTE_LAST)
    else $error("Byte frame overran eleven bits");
  AST_PING_ADV: assert property (phase_q == PH_PING && tx_done && pkt_q.hdr == HDR_EOP
    |=> phase_q != PH_IDCFG)
    else $error("Left ping after End of Power");
  CVR_XFER: cover property (phase_q == PH_IDCFG ##1 phase_q == PH_XFER);
  CVR_CLAMP: cover property ($rose(clamp_q) ##[1:50] $fell(clamp_q));
  CVR_PKT: cover property (tx_done && pkt_q.hdr == HDR_EOP && pkt_q.body == EOP_OT);
endmodule : wrx_ctrl
`default_nettype wire

// file: wrx_tx_model.sv
// Transmitter-side model: recovers packets from the load-modulation switches.
// Assumes idle-low switches and HALF_BIT clk_sys cycles per half bit.
`default_nettype none
module wrx_tx_model #(
  parameter int HALF_BIT = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Modulation switches
  input wire logic coil_input_a_sw,
  input wire logic coil_input_b_sw,
  // Decoded packets
  output logic [7:0] rx_hdr,
  output logic [7:0] rx_body,
  output int n_pkts,
  output int n_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [32:0] bits;
  logic [7:0] by [3];
  logic l1;
  logic l2;
  logic prev;
  initial begin
    rx_hdr = 8'h00;
    rx_body = 8'h00;
    n_pkts = 0;
    n_bad = 0;
    forever begin : rx_frame
      @(posedge coil_input_a_sw);
      prev = 1'b0;
      // Sample inside each half bit, clear of the toggle edges
      repeat (HALF_BIT / 2) @(negedge clk_sys);
      for (int b = 0; b < 33; b++) begin
        l1 = coil_input_a_sw;
        if (coil_input_b_sw !== l1) n_bad++;
        if (l1 === prev) n_bad++;
        repeat (HALF_BIT) @(negedge clk_sys);
        l2 = coil_input_a_sw;
        bits[b] = l1 ^ l2;
        prev = l2;
        // Re-arm early: the next packet may start one cycle after this one
        if (b < 32) repeat (HALF_BIT) @(negedge clk_sys);
      end
      for (int k = 0; k < 3; k++) begin
        by[k] = bits[11*k+1 +: 8];
        if (bits[11*k] !== 1'b0 || bits[11*k+10] !== 1'b1) n_bad++;
        if (^bits[11*k+1 +: 9] !== 1'b1) n_bad++;
      end
      if ((by[0] ^ by[1]) !== by[2]) n_bad++;
      rx_hdr = by[0];
      rx_body = by[1];
      n_pkts++;
    end
  end
  // A reset cuts a packet short; drop it and wait for the next start
  always @(posedge rst) disable rx_frame;
endmodule : wrx_tx_model
`default_nettype wire

// file: wireless_rx_protect_comm_ctrl_tb.sv
// Testbench of the receiver control block: registers, protection, rail
// target, FOD level and packet flow seen through the transmitter model.
`default_nettype none
module wireless_rx_protect_comm_ctrl_tb;
  import wrx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HB = 4;
  localparam logic [7:0] ID_B = 8'h5A;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [7:0] EV_HDR [6] = '{HDR_EOP, HDR_EOP, HDR_CS, HDR_EOC, HDR_EOP, HDR_EOP};
  localparam logic [7:0] EV_BODY [6] = '{EOP_OT, EOP_CHG, CS_FULL, 8'h00, EOP_OC, EOP_OT};
  localparam logic [1:0] EV_CTRL [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  localparam logic [16:0] LR [4] = '{17'h0_7530, 17'h0_61A8, 17'h0_61A7, 17'h0_4E20};
  localparam logic [15:0] LE [4] = '{16'h05DC, 16'h0708, 16'h07D0, 16'h07D0};
  localparam logic [15:0] IO [4] = '{16'h0032, 16'h0096, 16'h012C, 16'h01F4};
  localparam logic [15:0] TE [4] = '{TGT_R1_MV, TGT_R2_MV, TGT_R3_MV, TGT_R4_MV};
  localparam logic [3:0] FP [5] = '{4'h2, 4'h2, 4'h9, 4'hC, 4'h0};
  localparam logic [3:0] FO [5] = '{4'h6, 4'h0, 4'hF, 4'h6, 4'h7};
  localparam logic [15:0] FE [5] = '{16'h0140, 16'h0014, 16'h034C, 16'h0400, 16'h0132};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rv;
  wrx_meas_t meas = {16'h1388, 16'h1964, 16'h0032};
  logic die_hot = 1'b0;
  logic [16:0] limit_resistor = 17'h0_9470;
  logic [3:0] fod_profile_select = 4'h2;
  logic [3:0] fod_offset_select = 4'h6;
  logic sleep_req_n = 1'b0;
  logic thermal_stop_input = 1'b0;
  logic charge_done_input = 1'b0;
  logic ldo_en, rail_clamp_a, rail_clamp_b, pin_clamp, power_ok_n, fault_n, sleep_mode;
  logic coil_input_a_sw, coil_input_b_sw;
  wrx_rect_t rect_mode;
  logic [15:0] rail_target_mv, fod_level_mw;
  logic [7:0] rx_hdr, rx_body;
  int n_pkts, n_bad;
  int failures = 0;
  int n_tests = 0;
  always #4 clk_sys = ~clk_sys;
  wrx_ctrl #(.HALF_BIT(HB), .ID_BODY(ID_B)) wrx_ctrl_i (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .meas, .die_hot, .limit_resistor, .fod_profile_select,
    .fod_offset_select, .sleep_req_n, .thermal_stop_input, .charge_done_input, .ldo_en,
    .rail_clamp_a, .rail_clamp_b, .pin_clamp, .rect_mode, .rail_target_mv, .power_ok_n,
    .fault_n, .sleep_mode, .fod_level_mw, .coil_input_a_sw, .coil_input_b_sw);
  wrx_tx_model #(.HALF_BIT(HB)) wrx_tx_model_i (.clk_sys, .rst, .coil_input_a_sw,
    .coil_input_b_sw, .rx_hdr, .rx_body, .n_pkts, .n_bad);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // Waits packet by packet, each under a bound, for the given header
  task automatic wpkt(input logic [7:0] h, input int tries, output logic [7:0] b);
    int n0;
    b = 8'h00;
    for (int t = 0; t < tries; t++) begin
      n0 = n_pkts;
      for (int c = 0; c < 400 && n_pkts == n0; c++) @(posedge clk_sys);
      if (n_pkts != n0 && rx_hdr === h) begin
        b = rx_body;
        return;
      end
    end
    // A stale header from an earlier packet must not pass a timed-out wait
    chk("packet header", 32'(h), (n_pkts != n0) ? 32'(rx_hdr) : 32'hFFFF_FFFF);
  endtask : wpkt
  task automatic up();
    logic [7:0] b;
    rst <= 1'b1;
    meas.rectified_rail_mv <= 16'h1C20;
    cyc(16);
    rst <= 1'b0;
    wpkt(HDR_SS, 1, b);
    chk("power_ok_n", ONE, 32'(power_ok_n));
    wpkt(HDR_ID, 1, b);
    chk("id body", 32'(ID_B), 32'(b));
    wpkt(HDR_CFG, 1, b);
    wpkt(HDR_CE, 1, b);
    chk("power_ok_n", ZERO, 32'(power_ok_n));
  endtask : up
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] b;
    repeat (16) @(posedge clk_sys);
    chk("fault_n", ONE, 32'(fault_n));
    chk("ldo_en", ZERO, 32'(ldo_en));
    rst <= 1'b0;
    cyc(4);
    chk("rect wpc", 32'(RECT_DIODE), 32'(rect_mode));
    wr(REG_CTRL, 32'h0000_0002);
    cyc(4);
    chk("rect pma", 32'(RECT_HALF), 32'(rect_mode));
    up();
    chk("frame errors", ZERO, 32'(n_bad));
    rd(REG_STAT, rv);
    chk("status", 32'h0000_005C, rv);
    for (int i = 0; i < 4; i++) begin
      limit_resistor <= LR[i];
      cyc(3);
      rd(REG_LIMIT, rv);
      chk("current limit", 32'(LE[i]), rv);
    end
    limit_resistor <= 17'h0_9470;
    for (int i = 0; i < 4; i++) begin
      meas.iout_ma <= IO[i];
      cyc(4);
      chk("rail target", 32'(TE[i]), 32'(rail_target_mv));
    end
    meas.iout_ma <= 16'h0032;
    wr(REG_FOD, 32'h0000_0400);
    for (int i = 0; i < 5; i++) begin
      fod_profile_select <= FP[i];
      fod_offset_select <= FO[i];
      cyc(4);
      chk("fod level", 32'(FE[i]), 32'(fod_level_mw));
    end
    rd(8'h20, rv);
    chk("unmapped read", ZERO, rv);
    chk("ldo_en", ONE, 32'(ldo_en));
    meas.rectified_rail_mv <= 16'h42CC;
    cyc(3);
    chk("clamp a", ONE, 32'(rail_clamp_a));
    chk("fault_n", ZERO, 32'(fault_n));
    meas.rectified_rail_mv <= 16'h413C;
    cyc(3);
    chk("clamp b", ONE, 32'(rail_clamp_b));
    meas.rectified_rail_mv <= 16'h4010;
    cyc(3);
    chk("clamp off", ZERO, 32'(rail_clamp_a | rail_clamp_b));
    meas.rectified_rail_mv <= 16'h1C20;
    rd(REG_FAULT, rv);
    chk("fault flags", 32'h0000_0002, rv);
    wr(REG_FAULT, 32'h0000_0002);
    cyc(2);
    chk("fault_n", ONE, 32'(fault_n));
    meas.vin_mv <= 16'h3AFC;
    cyc(3);
    chk("pin clamp", ONE, 32'(pin_clamp));
    chk("ldo_en", ZERO, 32'(ldo_en));
    meas.vin_mv <= 16'h1388;
    for (int k = 0; k < 6; k++) begin
      up();
      wr(REG_CTRL, 32'(EV_CTRL[k]));
      case (k)
        0: thermal_stop_input <= 1'b1;
        4: meas.iout_ma <= 16'h04B0;
        5: die_hot <= 1'b1;
        default: charge_done_input <= 1'b1;
      endcase
      wpkt(EV_HDR[k], 4, b);
      if (k != 3) chk("event body", 32'(EV_BODY[k]), 32'(b));
      if (EV_HDR[k] == HDR_EOP) chk("ldo_en", ZERO, 32'(ldo_en));
      if (k == 0 || k > 3) chk("fault_n", ZERO, 32'(fault_n));
      thermal_stop_input <= 1'b0;
      charge_done_input <= 1'b0;
      die_hot <= 1'b0;
      meas.iout_ma <= 16'h0032;
    end
    up();
    sleep_req_n <= 1'b1;
    cyc(6);
    chk("sleep_mode", ONE, 32'(sleep_mode));
    chk("coil switch", ZERO, 32'(coil_input_a_sw));
    sleep_req_n <= 1'b0;
    cyc(6);
    chk("sleep_mode", ZERO, 32'(sleep_mode));
    tally_and_finish();
  end
endmodule : wireless_rx_protect_comm_ctrl_tb
`default_nettype wire
